// ### rtl/cmcrc_checker.sv
// Configuration memory CRC checker: frame checks, array checksum, scan-loaded check value

module cmcrc_checker import cmcrc_pkg::*; #(
   parameter int CELL_W     = CELL_W_DEF,
   parameter int CELL_WORDS = CELL_WORDS_DEF,
   parameter int ADDR_W     = $clog2(CELL_WORDS)
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   input  wire logic              user_mode,
   input  wire logic              ed_enable,
   input  wire logic [3:0]        div_exp,
   input  wire logic              cfg_bit_valid,
   input  wire logic              cfg_bit,
   input  wire logic              cfg_frame_done,
   input  wire logic              cfg_sig_load,
   input  wire logic [SIG_W-1:0]  cfg_sig_value,
   output logic      [ADDR_W-1:0] cell_addr,
   input  wire logic [CELL_W-1:0] cell_data,
   input  wire logic [IR_W-1:0]   jtag_ir,
   input  wire logic              jtag_shift,
   input  wire logic              jtag_tdi,
   output logic                   jtag_tdo,
   output logic                   jtag_tdo_oe,
   output logic                   config_status_n,
   output logic                   soft_error,
   output logic                   pass_done,
   output logic      [SIG_W-1:0]  crc_result_signature,
   output logic      [SIG_W-1:0]  precomputed_crc_value
);

   cmcrc_state_type          state;
   cmcrc_state_type          next_state;
   logic                     tick;
   logic                     run;
   logic                     chain_sel;
   logic                     chain_shift;
   logic [FRAME_CRC_W-1:0]   frame_crc;
   logic [FRAME_CRC_W-1:0]   frame_step;
   logic [FRAME_CRC_W-1:0]   next_frame_crc;
   logic [SIG_W-1:0]         array_crc;
   logic [SIG_W-1:0]         array_step;
   logic [SIG_W-1:0]         next_signature;
   logic [ADDR_W-1:0]        last_addr;

   assign last_addr = ADDR_W'(CELL_WORDS - 1);
   assign run       = user_mode && ed_enable;

   // Checker rate from the oscillator divider
   cmcrc_clk_div u_clk_div (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .div_exp  (div_exp),
      .tick     (tick)
   );

   // ---------------- Configuration frame check ----------------

   // Serial 16-bit frame checksum
   cmcrc_crc_step #(
      .CRC_W  (FRAME_CRC_W),
      .DATA_W (1),
      .POLY   (CRC16_POLY)
   ) u_frame_crc (
      .crc_in  (frame_crc),
      .data_in (cfg_bit),
      .crc_out (frame_step)
   );

   // Precomputed CRC bits pass through the same divider as the data, so a match leaves zero
   assign next_frame_crc = cfg_bit_valid ? frame_step : frame_crc;

   // Frame accumulator restarts after every frame, whatever its length
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_crc <= CRC16_INIT;
      end else if (clk_en) begin
         if (cfg_frame_done) begin
            frame_crc <= CRC16_INIT;
         end else begin
            frame_crc <= next_frame_crc;
         end
      end
   end

   // Status falls on a bad frame and stays low until reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         config_status_n <= 1'b1;
      end else if (clk_en && cfg_frame_done && (next_frame_crc != CRC16_INIT)) begin
         config_status_n <= 1'b0;
      end
   end

   // ---------------- Storage register and scan chain ----------------

   // Scan only in user mode; device keeps running meanwhile
   assign chain_sel   = user_mode && (jtag_ir == LOAD_CHECK_VALUE_CODE);
   assign chain_shift = clk_en && chain_sel && jtag_shift;
   assign jtag_tdo    = precomputed_crc_value[0];
   assign jtag_tdo_oe = chain_sel && jtag_shift;

   // End-of-configuration load wins over a scan shift in the same cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         precomputed_crc_value <= STORAGE_RST;
      end else if (clk_en && cfg_sig_load) begin
         precomputed_crc_value <= cfg_sig_value;
      end else if (chain_shift) begin
         precomputed_crc_value <= {jtag_tdi, precomputed_crc_value[SIG_W-1:1]};
      end
   end

   // ---------------- User-mode array checksum ----------------

   // One word per checker tick, IEEE 802 polynomial
   cmcrc_crc_step #(
      .CRC_W  (SIG_W),
      .DATA_W (CELL_W),
      .POLY   (CRC32_POLY)
   ) u_array_crc (
      .crc_in  (array_crc),
      .data_in (cell_data),
      .crc_out (array_step)
   );

   // Compare against the live storage value; injected errors show on the next pass
   assign next_signature = (array_crc ^ CRC32_XOROUT) ^ precomputed_crc_value;
   assign pass_done      = tick && (state == CMCRC_FINISH) && run;

   // Sequence: wait for user mode, walk the array, finish, start over
   always_comb begin
      next_state = state;
      case (state)
         CMCRC_IDLE: begin
            if (run) begin
               next_state = CMCRC_SCAN;
            end
         end
         CMCRC_SCAN: begin
            if (!run) begin
               next_state = CMCRC_IDLE;
            end else if (tick && (cell_addr == last_addr)) begin
               next_state = CMCRC_FINISH;
            end
         end
         CMCRC_FINISH: begin
            if (!run) begin
               next_state = CMCRC_IDLE;
            end else if (tick) begin
               next_state = CMCRC_SCAN;
            end
         end
         default: begin
            next_state = CMCRC_IDLE;
         end
      endcase
   end

   // State register; the scan chain never stalls it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= CMCRC_IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // Array address and running CRC, fresh start each pass
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cell_addr <= '0;
         array_crc <= CRC32_INIT;
      end else if (clk_en) begin
         if (state != CMCRC_SCAN) begin
            cell_addr <= '0;
            if (state == CMCRC_IDLE || tick) begin
               array_crc <= CRC32_INIT;
            end
         end else if (tick) begin
            array_crc <= array_step;
            cell_addr <= (cell_addr == last_addr) ? '0 : cell_addr + ADDR_W'(1);
         end
      end
   end

   // Signature and error output change only at pass end; a clean pass clears
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_result_signature <= SIGNATURE_RST;
         soft_error           <= 1'b0;
      end else if (clk_en && pass_done) begin
         crc_result_signature <= next_signature;
         soft_error           <= (next_signature != SIGNATURE_RST);
      end
   end

   // ---------------- Checks ----------------

   a_err_from_sig: assert property (@(posedge core_clk) disable iff (!rst_n)
      soft_error == (crc_result_signature != 32'h00000000))
      else $error("soft_error disagrees with signature");

   a_err_held_between: assert property (@(posedge core_clk) disable iff (!rst_n)
      !pass_done |=> $stable(soft_error) && $stable(crc_result_signature))
      else $error("soft_error changed outside pass end");

   a_sig_result: assert property (@(posedge core_clk) disable iff (!rst_n)
      pass_done |=> crc_result_signature == $past(next_signature))
      else $error("signature not taken at pass end");

   a_clean_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
      pass_done && (next_signature == 32'h00000000) |=> !soft_error)
      else $error("clean pass left soft_error high");

   a_frame_status: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_frame_done && (next_frame_crc != 16'h0000) |=> !config_status_n [*3])
      else $error("bad frame did not pull status low");

   a_store_load: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_sig_load |=> precomputed_crc_value == $past(cfg_sig_value))
      else $error("check value not loaded");

   a_chain_shift: assert property (@(posedge core_clk) disable iff (!rst_n)
      chain_shift && !cfg_sig_load |=>
         precomputed_crc_value == {$past(jtag_tdi), $past(precomputed_crc_value[31:1])})
      else $error("scan chain shift wrong");

   a_auto_start: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && (state == CMCRC_IDLE) && run |=> state == CMCRC_SCAN)
      else $error("checker did not start in user mode");

   a_keeps_running: assert property (@(posedge core_clk) disable iff (!rst_n)
      pass_done && clk_en |=> (state == CMCRC_SCAN) && (cell_addr == '0))
      else $error("checker stopped after a pass");

   a_no_halt: assert property (@(posedge core_clk) disable iff (!rst_n)
      chain_shift && (state == CMCRC_SCAN) && run && tick && (cell_addr != last_addr)
         |=> (state == CMCRC_SCAN) && (cell_addr == $past(cell_addr) + ADDR_W'(1)))
      else $error("scan shift stalled the checker");

   // Frame side: every frame starts from a clean accumulator, good frames leave status alone
   a_frame_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_frame_done |=> frame_crc == 16'h0000)
      else $error("frame checksum not restarted");

   a_good_frame: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_frame_done && (next_frame_crc == 16'h0000) && config_status_n
         |=> config_status_n)
      else $error("good frame pulled status low");

   a_status_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
      !config_status_n |=> !config_status_n)
      else $error("status released before reset");

   // Storage moves only on a load or a selected shift; outside user mode the host cannot reach it
   a_store_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(clk_en && cfg_sig_load) && !chain_shift |=> $stable(precomputed_crc_value))
      else $error("check value moved without load or shift");

   a_oe_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
      !user_mode || (jtag_ir != LOAD_CHECK_VALUE_CODE) |-> !jtag_tdo_oe)
      else $error("test data out driven while chain not selected");

   // Walk sequencing: last word ends the scan, a pass restarts clean, detection off parks it
   a_last_word: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && (state == CMCRC_SCAN) && run && tick && (cell_addr == last_addr)
         |=> state == CMCRC_FINISH)
      else $error("scan did not finish on the last word");

   a_pass_fresh: assert property (@(posedge core_clk) disable iff (!rst_n)
      pass_done |=> array_crc == 32'hFFFFFFFF)
      else $error("next pass did not restart the checksum");

   a_stop_when_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && !run |=> state == CMCRC_IDLE)
      else $error("checker kept walking with detection off");

   // Enable low must hold every piece of state, the walk included
   a_enable_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
      !clk_en |=> $stable(state) && $stable(cell_addr) && $stable(array_crc)
         && $stable(precomputed_crc_value) && $stable(config_status_n))
      else $error("state changed while enable was low");

endmodule // cmcrc_checker

// ### common/cmcrc_pkg.sv
// Shared constants and types for the configuration memory CRC checker
package cmcrc_pkg;

   // Signature and storage, frame checksum and instruction register widths
   localparam int          SIG_W           = 32;
   localparam int          FRAME_CRC_W     = 16;
   localparam int          IR_W            = 10;

   // Check-value scan instruction code
   localparam logic [9:0]  LOAD_CHECK_VALUE_CODE = 10'h015;

   // Whole-array checksum, IEEE 802 generator, MSB first
   localparam logic [31:0] CRC32_POLY      = 32'h04C11DB7;
   localparam logic [31:0] CRC32_INIT      = 32'hFFFFFFFF;
   localparam logic [31:0] CRC32_XOROUT    = 32'hFFFFFFFF;

   // Per-frame checksum; zero start so an appended good CRC leaves zero residue
   localparam logic [15:0] CRC16_POLY      = 16'h8005;
   localparam logic [15:0] CRC16_INIT      = 16'h0000;

   // Values after reset
   localparam logic [31:0] STORAGE_RST     = 32'h00000000;
   localparam logic [31:0] SIGNATURE_RST   = 32'h00000000;

   // Checker clock: oscillator rate, core rate, divider range
   localparam int          OSC_FREQ_MHZ    = 80;
   localparam int          CORE_FREQ_MHZ   = 100;
   localparam logic [7:0]  OSC_STEP        = 8'(OSC_FREQ_MHZ);
   localparam logic [7:0]  OSC_MOD         = 8'(CORE_FREQ_MHZ);
   localparam logic [3:0]  DIV_EXP_MAX     = 4'h8;

   // Default size of the cell array walk
   localparam int          CELL_W_DEF      = 32;
   localparam int          CELL_WORDS_DEF  = 1024;

   // User-mode checker sequence
   typedef enum logic [2:0] {
      CMCRC_IDLE   = 3'b001,
      CMCRC_SCAN   = 3'b010,
      CMCRC_FINISH = 3'b100
   } cmcrc_state_type;

endpackage

// ### rtl/cmcrc_crc_step.sv
// Parallel CRC update over one data word, MSB first
module cmcrc_crc_step import cmcrc_pkg::*; #(
   parameter int          CRC_W  = 32,
   parameter int          DATA_W = 32,
   parameter logic [CRC_W-1:0] POLY = '1
) (
   input  wire logic [CRC_W-1:0]  crc_in,
   input  wire logic [DATA_W-1:0] data_in,
   output logic      [CRC_W-1:0]  crc_out
);

   // Bit-serial LFSR unrolled across the word
   always_comb begin
      logic fb;
      fb      = 1'b0;
      crc_out = crc_in;
      for (int i = DATA_W - 1; i >= 0; i--) begin
         fb      = crc_out[CRC_W-1] ^ data_in[i];
         crc_out = {crc_out[CRC_W-2:0], 1'b0};
         if (fb) begin
            crc_out = crc_out ^ POLY;
         end
      end
   end

endmodule // cmcrc_crc_step

// ### rtl/cmcrc_clk_div.sv
// Checker clock enable: 80 MHz oscillator rate divided by 2^n
module cmcrc_clk_div import cmcrc_pkg::*; (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire logic [3:0] div_exp,
   output logic            tick
);

   logic [7:0] acc;
   logic [7:0] div_cnt;
   logic [8:0] acc_sum;
   logic       osc_pulse;
   logic [3:0] exp_lim;
   logic [7:0] div_mask;

   // Fractional accumulator: oscillator pulses at 80 of every 100 core cycles
   assign acc_sum   = {1'b0, acc} + {1'b0, OSC_STEP};
   assign osc_pulse = acc_sum >= {1'b0, OSC_MOD};
   // Out-of-range exponents are clamped to the slowest rate
   assign exp_lim   = (div_exp > DIV_EXP_MAX) ? DIV_EXP_MAX : div_exp;
   assign div_mask  = 8'((9'h001 << exp_lim) - 9'h001);
   assign tick      = clk_en && osc_pulse && ((div_cnt & div_mask) == 8'h00);

   // Oscillator phase
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= 8'h00;
      end else if (clk_en) begin
         acc <= osc_pulse ? 8'(acc_sum - {1'b0, OSC_MOD}) : acc_sum[7:0];
      end
   end

   // Power-of-two divider on oscillator pulses
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 8'h00;
      end else if (clk_en && osc_pulse) begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

endmodule // cmcrc_clk_div

// ### testbench/cmcrc_cell_model.sv
// Configuration cell array model answering the checker's word reads
module cmcrc_cell_model import cmcrc_pkg::*; #(
   parameter int CELL_W     = 32,
   parameter int CELL_WORDS = 4,
   parameter int ADDR_W     = 2
) (
   input  wire logic [ADDR_W-1:0] cell_addr,
   input  wire logic              upset,
   output logic      [CELL_W-1:0] cell_data
);
   timeunit 1ns;
   timeprecision 100ps;

   // Fixed pattern; upset flips one bit of word 2 as a particle strike would
   always_comb begin
      cell_data = CELL_W'(cell_addr) * CELL_W'(32'h01010101) ^ CELL_W'(32'h5A5A5A5A);
      if (upset && cell_addr == ADDR_W'(2)) begin
         cell_data = cell_data ^ CELL_W'(32'h00000020);
      end
   end
endmodule // cmcrc_cell_model

// ### testbench/cmcrc_checker_bench.sv
// Self-checking bench for the configuration memory CRC checker
module cmcrc_checker_bench import cmcrc_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WORDS   = 4;
   localparam int TIMEOUT = 20000;
   logic        core_clk, rst_n, clk_en, user_mode, ed_enable, upset;
   logic        cfg_bit_valid, cfg_bit, cfg_frame_done, cfg_sig_load;
   logic        jtag_shift, jtag_tdi, jtag_tdo, jtag_tdo_oe;
   logic        config_status_n, soft_error, pass_done;
   logic [3:0]  div_exp;
   logic [1:0]  cell_addr;
   logic [9:0]  jtag_ir;
   logic [31:0] cfg_sig_value, cell_data, crc_result_signature, precomputed_crc_value, good;
   int          mismatches, checks_done, cycle_count;

   cmcrc_checker #(.CELL_W(32), .CELL_WORDS(WORDS)) i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .user_mode(user_mode),
      .ed_enable(ed_enable), .div_exp(div_exp), .cfg_bit_valid(cfg_bit_valid),
      .cfg_bit(cfg_bit), .cfg_frame_done(cfg_frame_done), .cfg_sig_load(cfg_sig_load),
      .cfg_sig_value(cfg_sig_value), .cell_addr(cell_addr), .cell_data(cell_data),
      .jtag_ir(jtag_ir), .jtag_shift(jtag_shift), .jtag_tdi(jtag_tdi), .jtag_tdo(jtag_tdo),
      .jtag_tdo_oe(jtag_tdo_oe), .config_status_n(config_status_n), .soft_error(soft_error),
      .pass_done(pass_done), .crc_result_signature(crc_result_signature),
      .precomputed_crc_value(precomputed_crc_value));
   cmcrc_cell_model #(.CELL_W(32), .CELL_WORDS(WORDS), .ADDR_W(2)) i_cells (
      .cell_addr(cell_addr), .upset(upset), .cell_data(cell_data));

   // Free-running 100 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic wrap_up();
      if (mismatches == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog so a stuck pass cannot hang the run
   always @(posedge core_clk) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == TIMEOUT) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Reference checksum over the cell pattern, bit-serial so it shares only the package constants with the design
   function automatic logic [31:0] crc32_cells(input bit up);
      logic [31:0] c;
      logic [31:0] d;
      c = CRC32_INIT;
      for (int w = 0; w < WORDS; w++) begin
         d = 32'(w) * 32'h01010101 ^ 32'h5A5A5A5A ^ ((up && w == 2) ? 32'h00000020 : 32'h00000000);
         for (int b = 31; b >= 0; b--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[b]) ? CRC32_POLY : 32'h00000000);
      end
      return c ^ CRC32_XOROUT;
   endfunction

   function automatic logic [15:0] crc16(input logic [15:0] data, input int nbits);
      logic [15:0] c;
      c = CRC16_INIT;
      for (int b = nbits - 1; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ data[b]) ? CRC16_POLY : 16'h0000);
      return c;
   endfunction

   // Waits for the end of a pass, optionally holding soft_error to a level meanwhile
   task automatic wait_pass(input bit chk, input logic val, output int cyc);
      cyc = 0;
      do begin
         @(negedge core_clk);
         cyc++;
         if (chk && pass_done !== 1'b1) check(soft_error, val);
      end while (pass_done !== 1'b1 && cyc < 3000);
      check(pass_done, 1'b1);
   endtask

   task automatic send_frame(input logic [15:0] data, input int nbits, input logic [15:0] fcrc);
      for (int b = nbits + 15; b >= 0; b--) begin
         @(negedge core_clk);
         cfg_bit_valid = 1'b1;
         cfg_bit = (b > 15) ? data[b-16] : fcrc[b];
      end
      @(negedge core_clk);
      cfg_bit_valid = 1'b0;
      cfg_bit = ~cfg_bit;
      cfg_frame_done = 1'b1;
      @(negedge core_clk);
      cfg_frame_done = 1'b0;
      @(negedge core_clk);
   endtask

   // Shifts a new check value in, LSB first, while the checker keeps running
   task automatic shift_storage(input logic [31:0] nv, input logic [31:0] old);
      bit seen_pass;
      seen_pass = 1'b0;
      jtag_ir = LOAD_CHECK_VALUE_CODE;
      for (int i = 0; i < 32; i++) begin
         @(negedge core_clk);
         if (i == 0) check(jtag_tdo, old[0]);
         seen_pass |= (pass_done === 1'b1);
         jtag_shift = 1'b1;
         jtag_tdi = nv[i];
         #1 check(jtag_tdo_oe, 1'b1);
      end
      @(negedge core_clk);
      jtag_shift = 1'b0;
      jtag_tdi = 1'b1;
      @(negedge core_clk);
      @(negedge core_clk);
      check(precomputed_crc_value, nv);
      check(jtag_tdo, nv[0]);
      check(seen_pass, 1'b1);
   endtask

   task automatic t_frames();
      send_frame(16'hA5C3, 16, crc16(16'hA5C3, 16));
      check(config_status_n, 1'b1);
      send_frame(16'h005B, 8, crc16(16'h005B, 8));
      check(config_status_n, 1'b1);
      send_frame(16'h005B, 8, crc16(16'h005B, 8) ^ 16'h0001);
      check(config_status_n, 1'b0);
      check(pass_done, 1'b0);
   endtask

   task automatic t_load_and_clean();
      int cyc;
      cfg_sig_value = good;
      cfg_sig_load = 1'b1;
      @(negedge core_clk);
      cfg_sig_load = 1'b0;
      cfg_sig_value = ~good;
      @(negedge core_clk);
      check(precomputed_crc_value, good);
      user_mode = 1'b1;
      ed_enable = 1'b1;
      wait_pass(0, 1'b0, cyc);
      wait_pass(1, 1'b0, cyc);
      @(negedge core_clk);
      check(crc_result_signature, 32'h00000000);
      check(soft_error, 1'b0);
   endtask

   task automatic t_corrupt();
      int cyc;
      upset = 1'b1;
      wait_pass(1, 1'b0, cyc);
      @(negedge core_clk);
      check(soft_error, 1'b1);
      check(crc_result_signature, crc32_cells(1) ^ good);
      wait_pass(1, 1'b1, cyc);
      upset = 1'b0;
      wait_pass(1, 1'b1, cyc);
      @(negedge core_clk);
      check(soft_error, 1'b0);
      check(crc_result_signature, 32'h00000000);
   endtask

   task automatic t_inject();
      int cyc;
      shift_storage(good ^ 32'h00000100, good);
      wait_pass(0, 1'b0, cyc);
      wait_pass(0, 1'b0, cyc);
      @(negedge core_clk);
      check(crc_result_signature, 32'h00000100);
      check(soft_error, 1'b1);
      shift_storage(good, good ^ 32'h00000100);
      jtag_ir = LOAD_CHECK_VALUE_CODE ^ 10'h001;
      jtag_shift = 1'b1;
      jtag_tdi = 1'b0;
      #1 check(jtag_tdo_oe, 1'b0);
      wait_pass(0, 1'b0, cyc);
      wait_pass(0, 1'b0, cyc);
      jtag_shift = 1'b0;
      jtag_tdi = 1'b1;
      @(negedge core_clk);
      check(precomputed_crc_value, good);
      check(crc_result_signature, 32'h00000000);
   endtask

   // Enable low freezes the walk; detection off parks it at word 0 with no pass ends
   task automatic t_freeze();
      logic [1:0] addr_hold;
      addr_hold = cell_addr;
      clk_en = 1'b0;
      repeat (20) begin
         @(negedge core_clk);
         check(pass_done, 1'b0);
         check(cell_addr, addr_hold);
      end
      clk_en = 1'b1;
      ed_enable = 1'b0;
      repeat (20) begin
         @(negedge core_clk);
         check(pass_done, 1'b0);
      end
      check(cell_addr, 2'h0);
      check(soft_error, 1'b0);
      ed_enable = 1'b1;
   endtask

   // Pass length in core cycles: five ticks, each 2^n oscillator pulses at 4 per 5 cycles
   task automatic t_divider();
      int cyc;
      int total;
      logic [3:0] n_tab [4] = '{4'h0, 4'h3, 4'h8, 4'h9};
      int rep_tab [4] = '{4, 1, 1, 1};
      int exp_tab [4] = '{25, 50, 1600, 1600};
      for (int k = 0; k < 4; k++) begin
         div_exp = n_tab[k];
         wait_pass(0, 1'b0, cyc);
         wait_pass(0, 1'b0, cyc);
         total = 0;
         repeat (rep_tab[k]) begin
            wait_pass(0, 1'b0, cyc);
            total += cyc;
         end
         check(total, exp_tab[k]);
      end
   endtask

   // Main sequence: reset, configuration, user-mode checking
   initial begin
      {rst_n, clk_en, user_mode, ed_enable, upset, cfg_bit_valid, cfg_bit} = 7'h00;
      {cfg_frame_done, cfg_sig_load, jtag_shift} = 3'h0;
      {div_exp, jtag_ir, cfg_sig_value, jtag_tdi} = {14'h0000, 32'h00000000, 1'b1};
      {mismatches, checks_done, cycle_count} = {32'h0, 32'h0, 32'h0};
      good = crc32_cells(0);
      repeat (16) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      clk_en = 1'b1;
      @(negedge core_clk);
      check({soft_error, pass_done, config_status_n, jtag_tdo_oe}, 4'h2);
      check(crc_result_signature, SIGNATURE_RST);
      check(precomputed_crc_value, STORAGE_RST);
      t_frames();
      t_load_and_clean();
      t_corrupt();
      t_inject();
      t_freeze();
      t_divider();
      wrap_up();
   end
endmodule // cmcrc_checker_bench
